// file: seq_voltage_trip_params.svh
`ifndef SEQ_VOLTAGE_TRIP_PARAMS_SVH
`define SEQ_VOLTAGE_TRIP_PARAMS_SVH

// Timing
`define CLOCK_PERIOD_NS       5
`define PROGRAM_CYCLE_NS      5000000
`define MAX_OPERATE_MS        1800000
`define TICK_MS               5

// Register indices
`define REG_CONTROL           4'h0
`define REG_FIXED_DELAY       4'h1
`define REG_TIME_DIAL         4'h2
`define REG_EXPONENT          4'h3
`define REG_SETTING           4'h4
`define REG_VT_PRIMARY        4'h5
`define REG_RELEASE_TIME      4'h6
`define REG_STATUS            4'h7
`define REG_IRQ_STATUS        4'h8
`define REG_IRQ_MASK          4'h9
`define REG_EXPECTED_TIME     4'ha
`define REG_REMAINING         4'hb
`define REG_RATIO             4'hc
`define REG_PRIMARY_PICKUP    4'hd

// Field positions
`define CTRL_INVERSE_BIT      0
`define CTRL_UNDER_BIT        1
`define IRQ_START_BIT         0
`define IRQ_TRIP_BIT          1
`define IRQ_BLOCKED_BIT       2

// Reset values
`define RST_CONTROL           2'h0
`define RST_FIXED_DELAY       19'h00008
`define RST_TIME_DIAL         19'h0000a
`define RST_EXPONENT          12'h064
`define RST_SETTING           16'h2904
`define RST_VT_PRIMARY        24'h0003e8
`define RST_RELEASE_TIME      19'h0000c

// Pick-up release ratios in percent
`define RELEASE_OVER_PCT      97
`define RELEASE_UNDER_PCT     103

`endif

// file: seq_voltage_trip_pkg.sv
package seq_voltage_trip_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_STARTED,
      ST_TRIPPED,
      ST_RELEASING,
      ST_BLOCKED
   } state_type;

   typedef logic [18:0] ticks_type;

endpackage

// file: seq_voltage_trip_timing.sv
// Summary of operation
// - Blocking input is sampled at the start of every program cycle.
// - Pick-up without blocking asserts start and begins operating time counting.
// - Pick-up while blocked asserts blocked and does no start or trip processing.
// - Blocking during start clears start and runs release handling like pick-up reset.
// - Blocking emits display notification and blocking event with voltage and fault type.
// - Instant operation trips in the same cycle as start.
// - Fixed delay mode trips after set delay while pick-up stays active.
// - Inverse mode time is k over ratio power a minus one, or reversed.
// - Delay type selects fixed or inverse characteristic, fixed by default.
// - Fixed delay in 5 ms steps, default 40 ms, zero means instant.
// - Time dial k defaults to 0.05 s, used only in inverse mode.
// - Exponent a in 0.01 steps, default 1.00, used only in inverse mode.
// - Remaining time to trip reported signed in 5 ms steps.
// - Measured-to-setting ratio reported continuously in hundredths.
// - Primary pick-up voltage reported in 0.1 V from setting and scaling.
// - Pick-up releases at 97 percent over, 103 percent under.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "seq_voltage_trip_params.svh"

module seq_voltage_trip_timing #(
   parameter int unsigned TICK_CYCLES = `PROGRAM_CYCLE_NS / `CLOCK_PERIOD_NS
) (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_block,
   input  wire logic [15:0] i_measured_voltage,
   input  wire logic [3:0]  i_address,
   input  wire logic [31:0] i_write_data,
   input  wire logic        i_write,
   input  wire logic        i_read,
   output logic      [31:0] o_read_data,
   output logic             o_start,
   output logic             o_trip,
   output logic             o_blocked,
   output logic             o_irq,
   output logic             o_block_event,
   output logic             o_display_notify,
   output logic      [15:0] o_event_voltage,
   output logic             o_event_fault_type
);

   localparam logic [18:0] MAX_TICKS = 19'(`MAX_OPERATE_MS / `TICK_MS);
   localparam int          TICK_W    = $clog2(TICK_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Fixed-point helpers

   // Ratio in Q8.12, saturated
   function automatic logic [19:0] ratio_q12(input logic [15:0] um, input logic [15:0] us);
      logic [27:0] q;
      q = 28'h0;
      if (us == 16'h0) begin
         return 20'hfffff;
      end
      q = {um, 12'h000} / {12'h000, us};
      return (q > 28'h00fffff) ? 20'hfffff : q[19:0];
   endfunction

   // Base-two logarithm, Q.12, linear mantissa
   function automatic logic signed [23:0] log2_q12(input logic [19:0] x);
      logic [4:0]  p;
      logic [19:0] n;
      p = 5'h0;
      n = 20'h0;
      for (int i = 0; i < 20; i++) begin
         if (x[i]) begin
            p = 5'(i);
         end
      end
      if (x == 20'h0) begin
         return -24'sh0c0000;
      end
      n = x << (5'd19 - p);
      return ($signed({19'h0, p}) - 24'sd12) * 24'sd4096 + $signed({12'h0, n[18:7]});
   endfunction

   // Base-two power of a Q.12 exponent, result in Q8.12
   function automatic logic [19:0] pow2_q12(input logic signed [35:0] e);
      logic signed [35:0] n;
      logic [19:0]        m;
      n = e >>> 12;
      m = {7'h0, 1'b1, e[11:0]};
      if (n > 36'sd7) begin
         return 20'hfffff;
      end
      if (n < -36'sd12) begin
         return 20'h0;
      end
      return (n >= 0) ? (m << n[2:0]) : (m >> 4'(-n));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Program cycle divider

   logic [TICK_W-1:0] div_q;
   logic              tick;

   assign tick = (div_q == TICK_W'(TICK_CYCLES - 1));

   always_ff @(posedge i_clock) begin
      if (i_reset || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blocking input synchroniser

   logic [2:0] block_sync_q;
   logic       block_stable_q;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         block_sync_q   <= 3'h0;
         block_stable_q <= 1'b0;
      end else begin
         block_sync_q <= {block_sync_q[1:0], i_block};
         if (block_sync_q[1] == block_sync_q[2]) begin
            block_stable_q <= block_sync_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings registers

   logic [1:0]  control_q;
   logic [18:0] fixed_delay_q;
   logic [18:0] time_dial_q;
   logic [11:0] exponent_q;
   logic [15:0] setting_q;
   logic [23:0] vt_primary_q;
   logic [18:0] release_time_q;
   logic [2:0]  irq_status_q;
   logic [2:0]  irq_mask_q;
   logic [2:0]  irq_event;
   logic        inverse_mode;
   logic        under_mode;

   assign inverse_mode = control_q[`CTRL_INVERSE_BIT];
   assign under_mode   = control_q[`CTRL_UNDER_BIT];

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         control_q      <= `RST_CONTROL;
         fixed_delay_q  <= `RST_FIXED_DELAY;
         time_dial_q    <= `RST_TIME_DIAL;
         exponent_q     <= `RST_EXPONENT;
         setting_q      <= `RST_SETTING;
         vt_primary_q   <= `RST_VT_PRIMARY;
         release_time_q <= `RST_RELEASE_TIME;
         irq_mask_q     <= 3'h0;
      end else if (i_write) begin
         case (i_address)
            `REG_CONTROL:      control_q      <= i_write_data[1:0];
            `REG_FIXED_DELAY:  fixed_delay_q  <= i_write_data[18:0];
            `REG_TIME_DIAL:    time_dial_q    <= i_write_data[18:0];
            `REG_EXPONENT:     exponent_q     <= i_write_data[11:0];
            `REG_SETTING:      setting_q      <= i_write_data[15:0];
            `REG_VT_PRIMARY:   vt_primary_q   <= i_write_data[23:0];
            `REG_RELEASE_TIME: release_time_q <= i_write_data[18:0];
            `REG_IRQ_MASK:     irq_mask_q     <= i_write_data[2:0];
            default: ;
         endcase
      end
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         irq_status_q <= 3'h0;
      end else if (i_write && i_address == `REG_IRQ_STATUS) begin
         irq_status_q <= (irq_status_q & ~i_write_data[2:0]) | irq_event;
      end else begin
         irq_status_q <= irq_status_q | irq_event;
      end
   end

   assign o_irq = |(irq_status_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Pick-up comparator with hysteresis

   logic        pickup_q;
   logic        pickup_d;
   logic [23:0] scaled_vm;
   logic [23:0] scaled_release;

   assign scaled_vm = {8'h0, i_measured_voltage} * 24'd100;
   assign scaled_release = {8'h0, setting_q} *
                           (under_mode ? 24'd`RELEASE_UNDER_PCT : 24'd`RELEASE_OVER_PCT);

   always_comb begin
      if (under_mode) begin
         pickup_d = pickup_q ? (scaled_vm <= scaled_release) : (i_measured_voltage < setting_q);
      end else begin
         pickup_d = pickup_q ? (scaled_vm >= scaled_release) : (i_measured_voltage > setting_q);
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pickup_q <= 1'b0;
      end else if (tick) begin
         pickup_q <= pickup_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operating time calculation

   logic [19:0]        ratio;
   logic [19:0]        power;
   logic [19:0]        power_gap;
   logic signed [35:0] exp_prod;
   logic signed [23:0] ratio_log;
   logic [30:0]        inverse_ticks;
   logic [18:0]        op_time_d;
   logic [18:0]        op_time_q;
   logic [15:0]        ratio_pct_q;
   logic [31:0]        primary_q;
   logic [23:0]        ratio_pct_wide;
   logic [39:0]        primary_wide;

   assign ratio     = ratio_q12(i_measured_voltage, setting_q);
   assign ratio_log = log2_q12(ratio);
   assign exp_prod  = $signed({{12{ratio_log[23]}}, ratio_log}) *
                      $signed({24'h0, exponent_q}) / 36'sd100;
   assign power     = pow2_q12(exp_prod);
   assign power_gap = under_mode ? (20'h01000 - power) : (power - 20'h01000);
   assign inverse_ticks = {time_dial_q, 12'h000} / {11'h0, power_gap};

   always_comb begin
      if (!inverse_mode) begin
         op_time_d = fixed_delay_q;
      end else if ((under_mode ? power >= 20'h01000 : power <= 20'h01000) ||
                   inverse_ticks > {12'h0, MAX_TICKS}) begin
         op_time_d = MAX_TICKS;
      end else begin
         op_time_d = inverse_ticks[18:0];
      end
   end

   assign ratio_pct_wide = (setting_q == 16'h0) ? 24'hffffff : scaled_vm / {8'h0, setting_q};
   assign primary_wide   = {24'h0, setting_q} * {16'h0, vt_primary_q} / 40'd10000;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         op_time_q   <= `RST_FIXED_DELAY;
         ratio_pct_q <= 16'h0;
         primary_q   <= 32'h0;
      end else if (tick) begin
         op_time_q   <= op_time_d;
         ratio_pct_q <= ratio_pct_wide[15:0];
         primary_q   <= primary_wide[31:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start, trip and blocking sequence

   seq_voltage_trip_pkg::state_type state_q;
   logic [18:0] elapsed_q;
   logic [18:0] release_q;
   logic [18:0] elapsed_next;
   logic        block_now;
   logic        block_rise;

   assign block_now    = block_stable_q;
   assign elapsed_next = elapsed_q + 19'h1;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state_q   <= seq_voltage_trip_pkg::ST_IDLE;
         elapsed_q <= 19'h0;
         release_q <= 19'h0;
         o_start   <= 1'b0;
         o_trip    <= 1'b0;
         o_blocked <= 1'b0;
      end else if (tick) begin
         case (state_q)
            seq_voltage_trip_pkg::ST_IDLE: begin
               elapsed_q <= 19'h0;
               if (pickup_d && block_now) begin
                  state_q   <= seq_voltage_trip_pkg::ST_BLOCKED;
                  o_blocked <= 1'b1;
               end else if (pickup_d) begin
                  o_start <= 1'b1;
                  if (op_time_d == 19'h0) begin
                     state_q <= seq_voltage_trip_pkg::ST_TRIPPED;
                     o_trip  <= 1'b1;
                  end else begin
                     state_q <= seq_voltage_trip_pkg::ST_STARTED;
                  end
               end
            end
            seq_voltage_trip_pkg::ST_STARTED: begin
               if (block_now || !pickup_d) begin
                  state_q   <= seq_voltage_trip_pkg::ST_RELEASING;
                  o_start   <= 1'b0;
                  o_blocked <= block_now;
                  release_q <= 19'h0;
               end else begin
                  elapsed_q <= elapsed_next;
                  if (elapsed_next >= op_time_d) begin
                     state_q <= seq_voltage_trip_pkg::ST_TRIPPED;
                     o_trip  <= 1'b1;
                  end
               end
            end
            seq_voltage_trip_pkg::ST_TRIPPED: begin
               if (!pickup_d) begin
                  state_q <= seq_voltage_trip_pkg::ST_IDLE;
                  o_start <= 1'b0;
                  o_trip  <= 1'b0;
               end
            end
            seq_voltage_trip_pkg::ST_RELEASING: begin
               o_blocked <= block_now && pickup_d;
               if (pickup_d && !block_now) begin
                  state_q <= seq_voltage_trip_pkg::ST_STARTED;
                  o_start <= 1'b1;
               end else if (release_q >= release_time_q) begin
                  state_q   <= seq_voltage_trip_pkg::ST_IDLE;
                  o_blocked <= 1'b0;
               end else begin
                  release_q <= release_q + 19'h1;
               end
            end
            seq_voltage_trip_pkg::ST_BLOCKED: begin
               if (!pickup_d) begin
                  state_q   <= seq_voltage_trip_pkg::ST_IDLE;
                  o_blocked <= 1'b0;
               end
            end
            default: begin
               state_q <= seq_voltage_trip_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blocking event and interrupt events

   logic blocked_prev_q;
   logic start_prev_q;
   logic trip_prev_q;

   assign block_rise = o_blocked && !blocked_prev_q;
   assign irq_event  = {block_rise, o_trip && !trip_prev_q, o_start && !start_prev_q};

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         blocked_prev_q     <= 1'b0;
         start_prev_q       <= 1'b0;
         trip_prev_q        <= 1'b0;
         o_block_event      <= 1'b0;
         o_display_notify   <= 1'b0;
         o_event_voltage    <= 16'h0;
         o_event_fault_type <= 1'b0;
      end else begin
         blocked_prev_q   <= o_blocked;
         start_prev_q     <= o_start;
         trip_prev_q      <= o_trip;
         o_block_event    <= block_rise;
         o_display_notify <= block_rise;
         if (block_rise) begin
            o_event_voltage    <= i_measured_voltage;
            o_event_fault_type <= under_mode;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port

   logic signed [19:0] remaining;
   logic               counting;

   assign counting  = (state_q == seq_voltage_trip_pkg::ST_STARTED) ||
                      (state_q == seq_voltage_trip_pkg::ST_RELEASING);
   assign remaining = counting ? $signed({1'b0, op_time_q}) - $signed({1'b0, elapsed_q}) : 20'sh0;

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_read_data <= 32'h0;
      end else if (i_read) begin
         case (i_address)
            `REG_CONTROL:        o_read_data <= {30'h0, control_q};
            `REG_FIXED_DELAY:    o_read_data <= {13'h0, fixed_delay_q};
            `REG_TIME_DIAL:      o_read_data <= {13'h0, time_dial_q};
            `REG_EXPONENT:       o_read_data <= {20'h0, exponent_q};
            `REG_SETTING:        o_read_data <= {16'h0, setting_q};
            `REG_VT_PRIMARY:     o_read_data <= {8'h0, vt_primary_q};
            `REG_RELEASE_TIME:   o_read_data <= {13'h0, release_time_q};
            `REG_STATUS:         o_read_data <= {24'h0, 3'(state_q), block_stable_q, pickup_q,
                                                 o_blocked, o_trip, o_start};
            `REG_IRQ_STATUS:     o_read_data <= {29'h0, irq_status_q};
            `REG_IRQ_MASK:       o_read_data <= {29'h0, irq_mask_q};
            `REG_EXPECTED_TIME:  o_read_data <= {13'h0, op_time_q};
            `REG_REMAINING:      o_read_data <= {{12{remaining[19]}}, remaining};
            `REG_RATIO:          o_read_data <= {16'h0, ratio_pct_q};
            `REG_PRIMARY_PICKUP: o_read_data <= primary_q;
            default:             o_read_data <= 32'h0;
         endcase
      end else begin
         o_read_data <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   block_no_start_a : assert property (
      tick && state_q == seq_voltage_trip_pkg::ST_IDLE && pickup_d && block_now
      |=> o_blocked && !o_start && !o_trip)
      else $error("blocked pick-up produced start");

   start_unblocked_a : assert property (
      tick && state_q == seq_voltage_trip_pkg::ST_IDLE && pickup_d && !block_now
      |=> o_start && !o_blocked)
      else $error("unblocked pick-up gave no start");

   instant_trip_a : assert property (
      $rose(o_start) && op_time_q == 19'h0 && !inverse_mode |-> o_trip)
      else $error("instant trip not with start");

   block_clears_start_a : assert property (
      tick && state_q == seq_voltage_trip_pkg::ST_STARTED && block_now
      |=> !o_start && state_q == seq_voltage_trip_pkg::ST_RELEASING)
      else $error("blocking did not clear start");

   block_event_pulse_a : assert property (
      $rose(o_blocked) |=> o_block_event && o_display_notify ##1 !o_block_event)
      else $error("blocking event not a single pulse");

   trip_needs_start_a : assert property (
      $rose(o_trip) |-> o_start && (elapsed_q >= op_time_q || $rose(o_start)))
      else $error("trip before delay elapsed");

   fixed_mode_time_a : assert property (
      tick && !inverse_mode |=> op_time_q == $past(fixed_delay_q))
      else $error("fixed delay not used in fixed mode");

   saturate_max_a : assert property (
      op_time_q <= MAX_TICKS)
      else $error("operating time above maximum");

   remaining_value_a : assert property (
      tick && state_q == seq_voltage_trip_pkg::ST_STARTED && pickup_d && !block_now
      |=> o_trip || !$stable(op_time_q) || remaining == $past(remaining) - 20'sd1)
      else $error("remaining time did not count down");

   block_sample_a : assert property (
      !tick && state_q == seq_voltage_trip_pkg::ST_IDLE |=> $stable(o_start) && $stable(o_blocked))
      else $error("outputs changed outside program cycle");

   start_irq_set_a : assert property (
      $rose(o_start) |=> irq_status_q[`IRQ_START_BIT])
      else $error("start event not latched in status");

   trip_cover_c    : cover property ($rose(o_trip));
   blocked_cover_c : cover property ($rose(o_blocked) && state_q == seq_voltage_trip_pkg::ST_RELEASING);
   release_cover_c : cover property (state_q == seq_voltage_trip_pkg::ST_RELEASING ##1
                                     state_q == seq_voltage_trip_pkg::ST_STARTED);

endmodule

// file: seq_voltage_source.sv
`timescale 1ns/1ps
module seq_voltage_source (
   input  wire logic        i_clock,
   input  wire logic        i_block_request,
   input  wire logic [15:0] i_level,
   output logic             o_block,
   output logic      [15:0] o_measured_voltage
);
   initial begin
      o_block = 1'b0;
      o_measured_voltage = 16'h0000;
   end
   // Measuring stage output, one clock behind the level
   always @(posedge i_clock) begin
      o_measured_voltage <= i_level;
   end
   // Blocking raised well ahead of the set delay running out
   always @(posedge i_clock) begin
      o_block <= i_block_request;
   end
endmodule

// file: seq_voltage_trip_timing_tb_top.sv
`timescale 1ns/1ps
module seq_voltage_trip_timing_tb_top;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        block_req = 1'b0;
   logic [15:0] level = 16'h0000;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h00000000;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        block;
   logic [15:0] meas;
   logic [31:0] rdata;
   logic        start, trip, blocked, irq, blk_event, notify, ev_fault;
   logic [15:0] ev_volt;
   logic [31:0] r;
   int          err_total = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          n;

   always #2.5 clock = ~clock;

   seq_voltage_source i_src (.i_clock(clock), .i_block_request(block_req), .i_level(level),
      .o_block(block), .o_measured_voltage(meas));
   seq_voltage_trip_timing #(.TICK_CYCLES(8)) i_dut (.i_clock(clock), .i_reset(reset),
      .i_block(block), .i_measured_voltage(meas), .i_address(addr), .i_write_data(wdata),
      .i_write(wr_en), .i_read(rd_en), .o_read_data(rdata), .o_start(start), .o_trip(trip),
      .o_blocked(blocked), .o_irq(irq), .o_block_event(blk_event), .o_display_notify(notify),
      .o_event_voltage(ev_volt), .o_event_fault_type(ev_fault));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 r = rdata;
   endtask

   function automatic logic probe(input int sel);
      case (sel)
         0: return start;
         1: return trip;
         default: return blocked;
      endcase
   endfunction

   // Bounded wait for start, trip or blocked to reach a level
   task automatic await(input int sel, input logic lvl);
      n = 0;
      while (probe(sel) !== lvl && n < 600) begin
         @(posedge clock);
         #1 n++;
      end
      chk({31'h0, probe(sel)}, {31'h0, lvl});
   endtask

   task automatic settle(input logic [15:0] v);
      level <= v;
      await(0, 1'b0);
      repeat (120) @(posedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      logic [3:0]  a[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'he};
      logic [31:0] e[7] = '{32'h0, 32'h8, 32'ha, 32'h64, 32'h2904, 32'h0, 32'h0};
      wr(4'he, 32'h5a5a5a5a);
      for (int i = 0; i < 7; i++) begin
         rd(a[i]);
         chk(r, e[i]);
      end
      $display("defaults done");
   endtask

   task automatic t_fixed;
      wr(4'h9, 32'h2);
      level <= 16'h2af8;
      await(0, 1'b1);
      n = 0;
      while (trip !== 1'b1 && n < 200) begin
         @(posedge clock);
         #1 n++;
      end
      chk(n, 64);
      @(posedge clock);
      #1 chk({31'h0, irq}, 32'h1);
      rd(4'ha);
      chk(r, 32'h8);
      wr(4'h8, 32'h7);
      #1 chk({31'h0, irq}, 32'h0);
      settle(16'h2328);
      chk({31'h0, trip}, 32'h0);
      $display("fixed delay done");
   endtask

   task automatic t_instant;
      wr(4'h1, 32'h0);
      level <= 16'h2af8;
      await(0, 1'b1);
      chk({31'h0, trip}, 32'h1);
      settle(16'h2328);
      wr(4'h1, 32'h28);
      $display("instant done");
   endtask

   task automatic t_block;
      level <= 16'h2af8;
      await(0, 1'b1);
      block_req <= 1'b1;
      await(2, 1'b1);
      chk({31'h0, start}, 32'h0);
      @(posedge clock);
      #1 chk({30'h0, blk_event, notify}, 32'h3);
      chk({15'h0, ev_fault, ev_volt}, 32'h2af8);
      level <= 16'h2328;
      await(2, 1'b0);
      repeat (120) @(posedge clock);
      level <= 16'h2af8;
      await(2, 1'b1);
      repeat (100) @(posedge clock);
      chk({30'h0, start, trip}, 32'h0);
      block_req <= 1'b0;
      level <= 16'h2328;
      await(2, 1'b0);
      repeat (120) @(posedge clock);
      $display("blocking done");
   endtask

   task automatic t_remaining;
      level <= 16'h2af8;
      await(0, 1'b1);
      repeat (80) @(posedge clock);
      rd(4'hb);
      chk({31'h0, r > 0 && r < 40}, 32'h1);
      settle(16'h2328);
      $display("remaining done");
   endtask

   task automatic t_inverse;
      wr(4'h0, 32'h1);
      level <= 16'h5208;
      repeat (10) @(posedge clock);
      rd(4'hc);
      chk(r, 32'hc8);
      rd(4'hd);
      chk(r, 32'h41a);
      await(0, 1'b1);
      rd(4'ha);
      chk({31'h0, r >= 9 && r <= 11}, 32'h1);
      await(1, 1'b1);
      settle(16'h2328);
      $display("inverse done");
   endtask

   task automatic t_under;
      wr(4'h0, 32'h2);
      level <= 16'h2328;
      await(0, 1'b1);
      level <= 16'h2af8;
      await(0, 1'b0);
      wr(4'h0, 32'h3);
      level <= 16'h1482;
      await(0, 1'b1);
      rd(4'ha);
      chk(r, 32'h14);
      await(1, 1'b1);
      $display("under done");
   endtask

   task automatic give_verdict;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      level <= 16'h2328;
      t_defaults();
      t_fixed();
      t_instant();
      t_block();
      t_remaining();
      t_inverse();
      t_under();
      give_verdict();
   end
endmodule
